// File: src/bfdp_pkg.sv
// Constants, types and address map of the burst FIFO data port.
package bfdp_pkg;
   localparam int BFDP_CHANNELS = 8;
   localparam int BFDP_CH_W = 3;
   localparam int BFDP_ADDR_W = 12;
   localparam int BFDP_BUF_DEPTH = 16;
   // Channel region is 0x200 bytes; address bits 11:9 pick the channel.
   localparam int BFDP_CH_LSB = 9;
   localparam logic [8:0] BFDP_HOLD_OFS = 9'h000;
   localparam logic [8:0] BFDP_PLAIN_LO = 9'h100;
   localparam logic [8:0] BFDP_PLAIN_HI = 9'h13f;
   localparam logic [8:0] BFDP_STAT_LO = 9'h180;
   localparam logic [8:0] BFDP_STAT_HI = 9'h1ff;
   localparam logic [3:0] BFDP_LANE0 = 4'h1;
   localparam logic [1:0] BFDP_LAST_LANE = 2'h3;
   localparam logic [31:0] BFDP_RDATA_RST = 32'h0000_0000;
   localparam logic [7:0] BFDP_BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      BFDP_WIN_NONE = 2'h0,
      BFDP_WIN_HOLD = 2'h1,
      BFDP_WIN_PLAIN = 2'h2,
      BFDP_WIN_STAT = 2'h3
   } bfdp_win_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [BFDP_ADDR_W-1:0] addr;
      logic [3:0] be_n;
      logic [31:0] wdata;
   } bfdp_bus_req_t;

   typedef struct packed {
      logic [BFDP_CH_W-1:0] ch;
      logic [3:0] lanes;
      logic [31:0] data;
   } bfdp_tx_word_t;

   localparam int BFDP_TX_WORD_W = $bits(bfdp_tx_word_t);
endpackage

// File: src/bfdp_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module bfdp_fifo #(
   parameter int WIDTH = 39,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic do_push;
   logic do_pop;

   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign do_push = in_valid & in_ready;
   assign do_pop = out_valid & out_ready;

   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_r <= count_r + 1'b1;
         end else if (do_pop && !do_push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // bfdp_fifo

// File: src/bfdp_data_port.sv
// Burst data port moving host words into and out of eight channel byte FIFOs.
//
// Function
// RULE1 - Each channel N decodes a 64-byte burst window at 0xM00-0xM3F with M = 2N+1, writes fill TX, reads drain RX.
// RULE2 - Each channel also decodes a receive-with-status window at 0xM80-0xMFF.
// RULE3 - A whole 64-byte receive FIFO can be read from the plain window in 16 word reads.
// RULE4 - A plain window word read returns the oldest byte on bits 7:0 and later bytes in higher lanes.
// RULE5 - Each 16-bit half of a status window read holds status low and data high, older entry in the lower half.
// RULE6 - The full receive FIFO with status can be read in 32 word reads of the status window.
// RULE7 - The host reads the status window only with 16-bit or 32-bit accesses.
// RULE8 - A word written to the burst window pushes byte lane 0 first, then lanes 1, 2 and 3.
// RULE9 - Data ports accept 8, 16, 24 or 32-bit accesses, moving one byte per enabled lane.
// RULE10 - Burst reads and writes of up to 64 bytes work on the data ports.
// RULE11 - Bursts are accepted anywhere in the mapped region except reserved areas.
// RULE12 - The legacy holding byte at channel offset 0x000 is accessed as a single byte only.
// RULE13 - Each returned data byte pops exactly one receive entry, its status byte pops none.
// RULE14 - Writes meeting a full transmit FIFO are dropped without harming held entries.
`timescale 1ns/1ps
module bfdp_data_port
   import bfdp_pkg::*;
#(
   parameter int CHANNELS = bfdp_pkg::BFDP_CHANNELS,
   parameter int BUF_DEPTH = bfdp_pkg::BFDP_BUF_DEPTH
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Host data phase request, held until acknowledged.
   input wire bfdp_pkg::bfdp_bus_req_t hb_req,
   output logic hb_ack,
   output logic [31:0] hb_rdata,
   // Transmit FIFOs of the channels.
   input wire logic [CHANNELS-1:0] tx_full,
   output logic [CHANNELS-1:0] tx_push,
   output logic [7:0] tx_byte,
   // Receive FIFOs of the channels, head entry shown ahead of the pop.
   input wire logic [CHANNELS-1:0] rx_avail,
   input wire logic [CHANNELS*8-1:0] rx_head_data,
   input wire logic [CHANNELS*8-1:0] rx_head_status,
   output logic [CHANNELS-1:0] rx_pop
);
   import bfdp_pkg::*;

   typedef enum logic [3:0] {
      BFDP_ST_IDLE = 4'b0001,
      BFDP_ST_FETCH = 4'b0010,
      BFDP_ST_SETTLE = 4'b0100,
      BFDP_ST_REPLY = 4'b1000
   } bfdp_state_t;

   function automatic bfdp_win_t bfdp_decode(input logic [BFDP_ADDR_W-1:0] a);
      logic [8:0] ofs;
      ofs = a[8:0];
      if (ofs >= BFDP_PLAIN_LO && ofs <= BFDP_PLAIN_HI) begin
         bfdp_decode = BFDP_WIN_PLAIN; // RULE1
      end else if (ofs >= BFDP_STAT_LO && ofs <= BFDP_STAT_HI) begin
         bfdp_decode = BFDP_WIN_STAT; // RULE2
      end else if (ofs[8:2] == BFDP_HOLD_OFS[8:2]) begin
         bfdp_decode = BFDP_WIN_HOLD;
      end else begin
         bfdp_decode = BFDP_WIN_NONE;
      end
   endfunction

   // Byte lanes that move FIFO bytes for a given window and enables.
   function automatic logic [3:0] bfdp_lanes(input bfdp_win_t w, input logic [3:0] be_n);
      logic [3:0] be;
      be = ~be_n;
      unique case (w)
         BFDP_WIN_PLAIN: bfdp_lanes = be; // RULE9
         BFDP_WIN_HOLD: bfdp_lanes = be & BFDP_LANE0; // RULE12
         BFDP_WIN_STAT: bfdp_lanes = {be[3] | be[2], 1'b0, be[1] | be[0], 1'b0}; // RULE7
         default: bfdp_lanes = 4'h0;
      endcase
   endfunction

   function automatic logic [7:0] bfdp_pick(input logic [CHANNELS*8-1:0] v,
                                            input logic [BFDP_CH_W-1:0] ch);
      bfdp_pick = v[ch*8 +: 8];
   endfunction

   bfdp_win_t req_win;
   logic [BFDP_CH_W-1:0] req_ch;
   logic [3:0] req_lanes;
   logic req_new;
   logic wr_take;
   logic wr_skip;

   bfdp_state_t st_r;
   bfdp_win_t rd_win_r;
   logic [BFDP_CH_W-1:0] rd_ch_r;
   logic [3:0] rd_lanes_r;
   logic [1:0] rd_lane_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic [CHANNELS-1:0] rx_pop_r;

   bfdp_tx_word_t buf_in;
   bfdp_tx_word_t buf_out;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic drain_busy_r;
   bfdp_tx_word_t drain_word_r;
   logic [1:0] drain_lane_r;
   logic [CHANNELS-1:0] tx_push_r;
   logic [7:0] tx_byte_r;

   assign req_win = bfdp_decode(hb_req.addr);
   assign req_ch = hb_req.addr[BFDP_CH_LSB +: BFDP_CH_W];
   assign req_lanes = bfdp_lanes(req_win, hb_req.be_n);
   assign req_new = hb_req.valid & ~ack_r & (st_r == BFDP_ST_IDLE);

   // Transmit words go through the buffer; the status window is read only.
   assign wr_take = req_new & hb_req.write & (req_lanes != 4'h0) &
                    ((req_win == BFDP_WIN_PLAIN) | (req_win == BFDP_WIN_HOLD)) & buf_in_ready;
   assign wr_skip = req_new & hb_req.write & ((req_lanes == 4'h0) |
                    (req_win == BFDP_WIN_STAT) | (req_win == BFDP_WIN_NONE));

   assign buf_in.ch = req_ch;
   assign buf_in.lanes = req_lanes;
   assign buf_in.data = hb_req.wdata;
   assign buf_out_ready = ~drain_busy_r;

   bfdp_fifo #(
      .WIDTH(BFDP_TX_WORD_W),
      .DEPTH(BUF_DEPTH)
   ) u_tx_buf (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .in_valid(wr_take),
      .in_ready(buf_in_ready),
      .in_data(buf_in),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out)
   );

   // Acknowledge: writes as soon as buffered or skipped, reads after all lanes are fetched.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wr_take | wr_skip | (st_r == BFDP_ST_REPLY); // RULE10
      end
   end

   // Read sequencer: one lane per fetch, one settle cycle after each pop.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= BFDP_ST_IDLE;
         rd_win_r <= BFDP_WIN_NONE;
         rd_ch_r <= '0;
         rd_lanes_r <= 4'h0;
         rd_lane_r <= 2'h0;
         rdata_r <= BFDP_RDATA_RST;
         rx_pop_r <= '0;
      end else begin
         rx_pop_r <= '0;
         unique case (st_r)
            BFDP_ST_IDLE: begin
               if (req_new && !hb_req.write) begin
                  rd_win_r <= req_win;
                  rd_ch_r <= req_ch;
                  rd_lanes_r <= req_lanes;
                  rd_lane_r <= 2'h0;
                  rdata_r <= BFDP_RDATA_RST;
                  st_r <= (req_lanes == 4'h0) ? BFDP_ST_REPLY : BFDP_ST_FETCH; // RULE11
               end
            end
            BFDP_ST_FETCH: begin
               if (rd_lanes_r[rd_lane_r] && rx_avail[rd_ch_r]) begin
                  if (rd_win_r == BFDP_WIN_STAT) begin
                     // Status byte takes the lane below its data byte.
                     rdata_r[rd_lane_r*8 +: 8] <= bfdp_pick(rx_head_data, rd_ch_r); // RULE5
                     rdata_r[(rd_lane_r-2'h1)*8 +: 8] <= bfdp_pick(rx_head_status, rd_ch_r);
                  end else begin
                     rdata_r[rd_lane_r*8 +: 8] <= bfdp_pick(rx_head_data, rd_ch_r); // RULE4
                  end
                  rx_pop_r[rd_ch_r] <= 1'b1; // RULE13
                  st_r <= BFDP_ST_SETTLE;
               end else if (rd_lane_r == BFDP_LAST_LANE) begin
                  st_r <= BFDP_ST_REPLY;
               end else begin
                  rd_lane_r <= rd_lane_r + 2'h1;
               end
            end
            BFDP_ST_SETTLE: begin
               if (rd_lane_r == BFDP_LAST_LANE) begin
                  st_r <= BFDP_ST_REPLY; // RULE3 RULE6
               end else begin
                  rd_lane_r <= rd_lane_r + 2'h1;
                  st_r <= BFDP_ST_FETCH;
               end
            end
            BFDP_ST_REPLY: begin
               st_r <= BFDP_ST_IDLE;
            end
         endcase
      end
   end

   // Transmit drain: unpacks buffered words a lane at a time, lane 0 first.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         drain_busy_r <= 1'b0;
         drain_word_r <= '0;
         drain_lane_r <= 2'h0;
         tx_push_r <= '0;
         tx_byte_r <= BFDP_BYTE_RST;
      end else begin
         tx_push_r <= '0;
         if (!drain_busy_r) begin
            if (buf_out_valid) begin
               drain_word_r <= buf_out;
               drain_lane_r <= 2'h0;
               drain_busy_r <= 1'b1;
            end
         end else if (tx_push_r == '0) begin
            // The gap after each push lets the full flag catch up.
            if (drain_word_r.lanes[drain_lane_r] && !tx_full[drain_word_r.ch]) begin
               tx_push_r[drain_word_r.ch] <= 1'b1; // RULE8
               tx_byte_r <= drain_word_r.data[drain_lane_r*8 +: 8];
            end
            // A byte facing a full FIFO is simply passed over.
            if (drain_lane_r == BFDP_LAST_LANE) begin // RULE14
               drain_busy_r <= 1'b0;
            end else begin
               drain_lane_r <= drain_lane_r + 2'h1;
            end
         end
      end
   end

   assign hb_ack = ack_r;
   assign hb_rdata = rdata_r;
   assign tx_push = tx_push_r;
   assign tx_byte = tx_byte_r;
   assign rx_pop = rx_pop_r;
endmodule // bfdp_data_port

// File: tb/bfdp_data_port_sva.sv
// Concurrent checks on the ports of the burst FIFO data port.
`timescale 1ns/1ps
module bfdp_data_port_sva
   import bfdp_pkg::*;
#(
   parameter int CHANNELS = bfdp_pkg::BFDP_CHANNELS,
   parameter int BUF_DEPTH = bfdp_pkg::BFDP_BUF_DEPTH
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Host side.
   input wire bfdp_pkg::bfdp_bus_req_t hb_req,
   input wire logic hb_ack,
   input wire logic [31:0] hb_rdata,
   // Channel side.
   input wire logic [CHANNELS-1:0] tx_full,
   input wire logic [CHANNELS-1:0] tx_push,
   input wire logic [7:0] tx_byte,
   input wire logic [CHANNELS-1:0] rx_avail,
   input wire logic [CHANNELS*8-1:0] rx_head_data,
   input wire logic [CHANNELS*8-1:0] rx_head_status,
   input wire logic [CHANNELS-1:0] rx_pop
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   wire logic resv = hb_req.addr[8:0] >= 9'h004 && hb_req.addr[8:0] <= 9'h0ff;
   a_push_one_hot: assert property ($onehot0(tx_push))
      else $error("tx_push not one-hot");
   a_push_spaced: assert property (|tx_push |=> tx_push == '0)
      else $error("tx_push pulses back to back");
   a_push_not_full: assert property ((tx_push & $past(tx_full)) == '0)
      else $error("byte pushed into a full channel");
   a_pop_one_hot: assert property ($onehot0(rx_pop))
      else $error("rx_pop not one-hot");
   a_pop_spaced: assert property (|rx_pop |=> rx_pop == '0)
      else $error("rx_pop pulses back to back");
   a_pop_needs_avail: assert property ((rx_pop & ~$past(rx_avail)) == '0)
      else $error("pop of an empty channel");
   a_pop_in_read: assert property (|rx_pop |-> hb_req.valid && !hb_req.write)
      else $error("pop outside a read");
   a_ack_single: assert property (hb_ack |=> !hb_ack)
      else $error("hb_ack longer than one cycle");
   a_stat_wr_ack: assert property ($rose(hb_req.valid) && hb_req.write &&
      hb_req.addr[8:7] == 2'b11 |=> hb_ack) else $error("status window write not acked");
   a_resv_rd_zero: assert property ($rose(hb_req.valid) && !hb_req.write && resv
      |-> ##2 (hb_ack && hb_rdata == '0)) else $error("reserved read not answered with 0");
   c_read_ack: cover property (hb_ack && !hb_req.write);
   c_push: cover property (|tx_push);
   c_pop: cover property (|rx_pop);
   c_full: cover property (|tx_full);
endmodule // bfdp_data_port_sva
bind bfdp_data_port bfdp_data_port_sva #(.CHANNELS(CHANNELS), .BUF_DEPTH(BUF_DEPTH)) i_sva (
   .ref_clk(ref_clk), .rstn(rstn), .hb_req(hb_req), .hb_ack(hb_ack), .hb_rdata(hb_rdata),
   .tx_full(tx_full), .tx_push(tx_push), .tx_byte(tx_byte), .rx_avail(rx_avail),
   .rx_head_data(rx_head_data), .rx_head_status(rx_head_status), .rx_pop(rx_pop));

// File: tb/bfdp_chan_model.sv
// Behavioural model of the eight channel transmit and receive FIFOs.
`timescale 1ns/1ps
module bfdp_chan_model #(
   parameter int CHANNELS = 8,
   parameter int TX_CAP = 68
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Transmit side.
   input wire logic [CHANNELS-1:0] tx_push,
   output logic [CHANNELS-1:0] tx_full,
   // Receive side.
   input wire logic [CHANNELS-1:0] rx_pop,
   output logic [CHANNELS-1:0] rx_avail,
   output logic [CHANNELS*8-1:0] rx_head_data,
   output logic [CHANNELS*8-1:0] rx_head_status
);
   logic [15:0] rxq[CHANNELS][$];
   int txn[CHANNELS];
   int cyc = 0;
   task automatic load(input int c, input logic [7:0] d, input logic [7:0] s);
      rxq[c].push_back({d, s});
   endtask
   initial begin
      {tx_full, rx_avail, rx_head_data, rx_head_status} = '0;
   end
   // An empty head shows a changing pattern so that a stale read cannot pass.
   always @(posedge ref_clk) begin
      cyc++;
      for (int c = 0; c < CHANNELS; c++) begin
         if (!rstn) txn[c] = 0;
         else begin
            if (rx_pop[c] && rxq[c].size() > 0) void'(rxq[c].pop_front());
            if (tx_push[c]) txn[c]++;
         end
         tx_full[c] <= txn[c] >= TX_CAP;
         rx_avail[c] <= rxq[c].size() > 0;
         rx_head_data[8*c+:8] <= rxq[c].size() > 0 ? rxq[c][0][15:8] : 8'(cyc + c);
         rx_head_status[8*c+:8] <= rxq[c].size() > 0 ? rxq[c][0][7:0] : 8'(~cyc);
      end
   end
endmodule // bfdp_chan_model

// File: tb/burst_fifo_data_port_tb.sv
// Self-checking testbench of the burst FIFO data port.
`timescale 1ns/1ps
module burst_fifo_data_port_tb;
   import bfdp_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   bfdp_bus_req_t hb_req = '0;
   logic hb_ack;
   logic [31:0] hb_rdata;
   logic [7:0] tx_full, tx_push, tx_byte, rx_avail, rx_pop;
   logic [63:0] rx_head_data, rx_head_status;
   int n_errors = 0;
   int cmp_count = 0;
   logic [15:0] exp_tx[$];
   logic [32:0] exp_ack[$];
   logic [32:0] e;
   logic [7:0] dd[64];
   logic [7:0] ss[64];
   logic [31:0] d;
   initial forever #12.5 ref_clk = ~ref_clk;
   bfdp_data_port i_bfdp_data_port (.ref_clk(ref_clk), .rstn(rstn), .hb_req(hb_req),
      .hb_ack(hb_ack), .hb_rdata(hb_rdata), .tx_full(tx_full), .tx_push(tx_push),
      .tx_byte(tx_byte), .rx_avail(rx_avail), .rx_head_data(rx_head_data),
      .rx_head_status(rx_head_status), .rx_pop(rx_pop));
   bfdp_chan_model i_bfdp_chan_model (.ref_clk(ref_clk), .rstn(rstn), .tx_push(tx_push),
      .tx_full(tx_full), .rx_pop(rx_pop), .rx_avail(rx_avail), .rx_head_data(rx_head_data),
      .rx_head_status(rx_head_status));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] be,
      input logic [31:0] ed, input logic [31:0] wd);
      int k;
      @(negedge ref_clk);
      exp_ack.push_back({w, ed});
      hb_req = '{1'b1, w, a, be, wd};
      for (k = 0; k < 300 && hb_ack !== 1'b1; k++) @(negedge ref_clk);
      hb_req.valid = 1'b0;
      if (k == 300) begin
         n_errors++;
         results();
      end
   endtask
   task automatic wr(input int c, input logic [8:0] o, input logic [3:0] be, input logic [31:0] wd);
      for (int l = 0; l < 4; l++) if (!be[l]) exp_tx.push_back({8'(1 << c), wd[8*l+:8]});
      bus(1'b1, {3'(c), o}, be, 32'h0, wd);
   endtask
   task automatic fill(input int c, input int n);
      for (int i = 0; i < n; i++) begin
         dd[i] = 8'($urandom);
         ss[i] = 8'($urandom);
         i_bfdp_chan_model.load(c, dd[i], ss[i]);
      end
   endtask
   // Results are matched in the order that the driver noted them.
   always @(negedge ref_clk) begin
      if (tx_push !== 8'h00) check({tx_push, tx_byte}, exp_tx.size() ? exp_tx.pop_front() : 'x);
      if (hb_ack === 1'b1) begin
         e = exp_ack.size() ? exp_ack.pop_front() : 'x;
         if (e[32] !== 1'b1) check(hb_rdata, e[31:0]);
      end
   end
   initial begin
      d = $urandom(70);
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk) rstn = 1'b1;
      for (int c = 0; c < 8; c++) wr(c, 9'h100, 4'h0, $urandom);
      wr(2, 9'h104, 4'he, $urandom);
      wr(2, 9'h108, 4'hc, $urandom);
      wr(2, 9'h10c, 4'h8, $urandom);
      wr(4, 9'h100, 4'hf, $urandom);
      for (int k = 0; k < 16; k++) wr(3, 9'h100 + 9'(4 * k), 4'h0, $urandom);
      bus(1'b1, 12'h700, 4'h0, 32'h0, $urandom);
      wr(4, 9'h13c, 4'h0, $urandom);
      bus(1'b1, 12'h180, 4'h0, 32'h0, $urandom);
      bus(1'b1, 12'h140, 4'h0, 32'h0, $urandom);
      wr(2, 9'h000, 4'he, $urandom);
      fill(1, 64);
      for (int k = 0; k < 16; k++) bus(1'b0, 12'h300 + 12'(4 * k), 4'h0,
         {dd[4*k+3], dd[4*k+2], dd[4*k+1], dd[4*k]}, 32'h0);
      bus(1'b0, 12'h300, 4'h0, 32'h0, 32'h0);
      fill(5, 64);
      for (int k = 0; k < 32; k++) bus(1'b0, 12'hb80 + 12'(4 * k), 4'h0,
         {dd[2*k+1], ss[2*k+1], dd[2*k], ss[2*k]}, 32'h0);
      fill(5, 2);
      bus(1'b0, 12'hb80, 4'hc, {16'h0, dd[0], ss[0]}, 32'h0);
      bus(1'b0, 12'hb80, 4'h3, {dd[1], ss[1], 16'h0}, 32'h0);
      fill(1, 1);
      bus(1'b0, 12'h200, 4'he, {24'h0, dd[0]}, 32'h0);
      fill(6, 2);
      bus(1'b0, 12'hd00, 4'h8, {16'h0, dd[1], dd[0]}, 32'h0);
      bus(1'b0, 12'h004, 4'h0, 32'h0, 32'h0);
      for (int k = 0; k < 300 && exp_tx.size() > 0; k++) @(negedge ref_clk);
      if (exp_tx.size() > 0) n_errors++;
      results();
   end
   initial begin
      #2500000;
      n_errors++;
      results();
   end
endmodule // burst_fifo_data_port_tb
